// ### src/cis_pkg.sv
// Functional notes
// - The section's overall gain is the fifth-stage factor to the fourth, times the second-stage factor, over two to the gain shift.
// - The gain shift divides by a power of two at full accumulator precision after both stages; the stages may wrap, only the result must fit.
// - The gain shift is one setting shared by both channels at location 0x06 and holds values 0 through 25.
// - The first stage is a fifth-order integrator-comb interpolator with transfer ((1-z^-L)/(1-z^-1))^5.
// - The fifth-stage factor minus one is an 8-bit setting at location 0x09.
// - The second stage is a second-order integrator-comb interpolator after the first, transfer ((1-z^-L)/(1-z^-1))^2.
// - The second-stage factor minus one is an 8-bit setting at location 0x08.
// - In-phase and quadrature streams are interpolated together through both stages.
package cis_pkg;
	localparam int          IN_W          = 16;
	localparam int          ACC_W         = 48;
	localparam int          OUT_W         = 24;
	localparam int          DATA_W        = 2 * OUT_W;
	localparam logic [7:0]  ADDR_SHIFT    = 8'h06;
	localparam logic [7:0]  ADDR_SECOND   = 8'h08;
	localparam logic [7:0]  ADDR_FIFTH    = 8'h09;
	localparam logic [7:0]  SHIFT_MAX     = 8'h19;
	localparam logic [7:0]  SHIFT_RESET   = 8'h00;
	localparam logic [7:0]  SECOND_RESET  = 8'h00;
	localparam logic [7:0]  FIFTH_RESET   = 8'h00;
	localparam int          FIFTH_ORDER   = 5;
	localparam int          SECOND_ORDER  = 2;
	typedef logic signed [ACC_W-1:0] cis_acc_type;
endpackage : cis_pkg

// ### src/cis_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cis_stream_if;
	logic                          valid;
	logic                          ready;
	logic [cis_pkg::DATA_W-1:0]    data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : cis_stream_if
`default_nettype wire

// ### src/cis_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module cis_skid_buffer (
	input  wire logic     mclk,
	input  wire logic     sys_rst,
	cis_stream_if.snk     up,
	cis_stream_if.src     dn
);
	logic                          v0_reg;
	logic                          v1_reg;
	logic [cis_pkg::DATA_W-1:0]    d0_reg;
	logic [cis_pkg::DATA_W-1:0]    d1_reg;
	logic                          push;
	logic                          pop;

	// both ends come straight from flops; the second entry absorbs a stall
	assign up.ready = ~v1_reg;
	assign dn.valid = v0_reg;
	assign dn.data  = d0_reg;
	assign push     = up.valid & ~v1_reg;
	assign pop      = v0_reg & dn.ready;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
			d0_reg <= '0;
			d1_reg <= '0;
		end
		else if (v0_reg & ~pop)
		begin
			if (push)
			begin
				v1_reg <= 1'b1;
				d1_reg <= up.data;
			end
		end
		else if (v1_reg)
		begin
			v0_reg <= 1'b1;
			d0_reg <= d1_reg;
			v1_reg <= 1'b0;
		end
		else
		begin
			v0_reg <= push;
			d0_reg <= up.data;
		end
	end

	a_buf_no_loss : assert property (@(posedge mclk) disable iff (sys_rst)
		v0_reg & ~dn.ready |=> v0_reg && d0_reg == $past(d0_reg))
		else $error("buffer output changed while stalled");
endmodule : cis_skid_buffer
`default_nettype wire

// ### src/cis_interpolator.sv
`timescale 1ns/1ps
`default_nettype none
module cis_interpolator (
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic [7:0]                  cfg_addr,
	input  wire logic [7:0]                  cfg_wdata,
	input  wire logic                        cfg_wr_en,
	input  wire logic                        cfg_rd_en,
	output logic      [7:0]                  cfg_rdata,
	input  wire logic [cis_pkg::IN_W-1:0]    in_i,
	input  wire logic [cis_pkg::IN_W-1:0]    in_q,
	input  wire logic                        in_valid,
	output logic                             in_ready,
	output logic      [cis_pkg::OUT_W-1:0]   out_i,
	output logic      [cis_pkg::OUT_W-1:0]   out_q,
	output logic                             out_valid,
	input  wire logic                        out_ready
);
	localparam int N5 = cis_pkg::FIFTH_ORDER;
	localparam int N2 = cis_pkg::SECOND_ORDER;

	logic [7:0]               gain_shift_reg;
	logic [7:0]               fifth_factor_reg;
	logic [7:0]               second_factor_reg;
	logic [7:0]               cfg_rdata_reg;
	logic [7:0]               ph5_reg;
	logic [7:0]               ph2_reg;
	logic                     hold_full_reg;
	logic                     hold_full_next;
	logic                     in_ready_reg;
	logic [cis_pkg::IN_W-1:0] hold_i_reg;
	logic [cis_pkg::IN_W-1:0] hold_q_reg;
	logic                     take;
	logic                     need_in;
	logic                     adv;
	logic                     step_in;
	logic                     step5;
	cis_pkg::cis_acc_type     x_in [2];
	cis_pkg::cis_acc_type     co5_reg [2][N5];
	cis_pkg::cis_acc_type     dl5_reg [2][N5];
	cis_pkg::cis_acc_type     ig5_reg [2][N5];
	cis_pkg::cis_acc_type     co2_reg [2][N2];
	cis_pkg::cis_acc_type     dl2_reg [2][N2];
	cis_pkg::cis_acc_type     ig2_reg [2][N2];
	cis_pkg::cis_acc_type     sc_i;
	cis_pkg::cis_acc_type     sc_q;

	cis_stream_if buf_in ();
	cis_stream_if buf_out ();

	cis_skid_buffer u_buf (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.up      (buf_in.snk),
		.dn      (buf_out.src)
	);

	assign cfg_rdata     = cfg_rdata_reg;
	assign in_ready      = in_ready_reg;
	assign out_valid     = buf_out.valid;
	assign out_i         = buf_out.data[cis_pkg::DATA_W-1:cis_pkg::OUT_W];
	assign out_q         = buf_out.data[cis_pkg::OUT_W-1:0];
	assign buf_out.ready = out_ready;

	// configuration registers
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			gain_shift_reg    <= cis_pkg::SHIFT_RESET;
			second_factor_reg <= cis_pkg::SECOND_RESET;
			fifth_factor_reg  <= cis_pkg::FIFTH_RESET;
		end
		else if (cfg_wr_en)
		begin
			unique case (cfg_addr)
				cis_pkg::ADDR_SHIFT  : gain_shift_reg <= (cfg_wdata > cis_pkg::SHIFT_MAX) ?
							cis_pkg::SHIFT_MAX : cfg_wdata;
				cis_pkg::ADDR_SECOND : second_factor_reg <= cfg_wdata;
				cis_pkg::ADDR_FIFTH  : fifth_factor_reg <= cfg_wdata;
				default              : ;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_rdata_reg <= 8'h00;
		else if (cfg_rd_en)
		begin
			unique case (cfg_addr)
				cis_pkg::ADDR_SHIFT  : cfg_rdata_reg <= gain_shift_reg;
				cis_pkg::ADDR_SECOND : cfg_rdata_reg <= second_factor_reg;
				cis_pkg::ADDR_FIFTH  : cfg_rdata_reg <= fifth_factor_reg;
				default              : cfg_rdata_reg <= 8'h00;
			endcase
		end
	end

	// input hold register; ready is registered so it leaves from a flop
	assign take           = in_valid & in_ready_reg;
	assign hold_full_next = (hold_full_reg & ~step_in) | take;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hold_full_reg <= 1'b0;
			in_ready_reg  <= 1'b0;
			hold_i_reg    <= '0;
			hold_q_reg    <= '0;
		end
		else
		begin
			hold_full_reg <= hold_full_next;
			in_ready_reg  <= ~hold_full_next;
			if (take)
			begin
				hold_i_reg <= in_i;
				hold_q_reg <= in_q;
			end
		end
	end

	// one output step per cycle unless the buffer is full or a sample is late
	assign need_in = (ph2_reg == 8'h00) && (ph5_reg == 8'h00);
	assign adv     = buf_in.ready & (~need_in | hold_full_reg);
	assign step_in = adv & need_in;
	assign step5   = adv & (ph2_reg == 8'h00);
	assign x_in[0] = cis_pkg::cis_acc_type'(signed'(hold_i_reg));
	assign x_in[1] = cis_pkg::cis_acc_type'(signed'(hold_q_reg));

	// phase counters; >= keeps them bounded if a factor shrinks mid-run
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ph2_reg <= 8'h00;
			ph5_reg <= 8'h00;
		end
		else if (adv)
		begin
			ph2_reg <= (ph2_reg >= second_factor_reg) ? 8'h00 : ph2_reg + 8'h01;
			if (step5)
				ph5_reg <= (ph5_reg >= fifth_factor_reg) ? 8'h00 : ph5_reg + 8'h01;
		end
	end

	// fifth-order combs at input rate, integrators at fifth-stage rate
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int c = 0; c < 2; c++)
				for (int k = 0; k < N5; k++)
				begin
					co5_reg[c][k] <= '0;
					dl5_reg[c][k] <= '0;
				end
		end
		else if (step_in)
		begin
			for (int c = 0; c < 2; c++)
			begin
				co5_reg[c][0] <= x_in[c] - dl5_reg[c][0];
				dl5_reg[c][0] <= x_in[c];
				for (int k = 1; k < N5; k++)
				begin
					co5_reg[c][k] <= co5_reg[c][k-1] - dl5_reg[c][k];
					dl5_reg[c][k] <= co5_reg[c][k-1];
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int c = 0; c < 2; c++)
				for (int k = 0; k < N5; k++)
					ig5_reg[c][k] <= '0;
		end
		else if (step5)
		begin
			for (int c = 0; c < 2; c++)
			begin
				// zero stuffing between input samples gives the L^4 gain
				if (ph5_reg == 8'h00)
					ig5_reg[c][0] <= ig5_reg[c][0] + co5_reg[c][N5-1];
				for (int k = 1; k < N5; k++)
					ig5_reg[c][k] <= ig5_reg[c][k] + ig5_reg[c][k-1];
			end
		end
	end

	// second-order combs at fifth-stage rate, integrators at output rate
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int c = 0; c < 2; c++)
				for (int k = 0; k < N2; k++)
				begin
					co2_reg[c][k] <= '0;
					dl2_reg[c][k] <= '0;
				end
		end
		else if (step5)
		begin
			for (int c = 0; c < 2; c++)
			begin
				co2_reg[c][0] <= ig5_reg[c][N5-1] - dl2_reg[c][0];
				dl2_reg[c][0] <= ig5_reg[c][N5-1];
				co2_reg[c][1] <= co2_reg[c][0] - dl2_reg[c][1];
				dl2_reg[c][1] <= co2_reg[c][0];
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int c = 0; c < 2; c++)
				for (int k = 0; k < N2; k++)
					ig2_reg[c][k] <= '0;
		end
		else if (adv)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (ph2_reg == 8'h00)
					ig2_reg[c][0] <= ig2_reg[c][0] + co2_reg[c][N2-1];
				ig2_reg[c][1] <= ig2_reg[c][1] + ig2_reg[c][0];
			end
		end
	end

	// shift at full width; wrap inside the stages is harmless, only the result must fit
	assign sc_i         = ig2_reg[0][N2-1] >>> gain_shift_reg;
	assign sc_q         = ig2_reg[1][N2-1] >>> gain_shift_reg;
	assign buf_in.valid = adv;
	assign buf_in.data  = {sc_i[cis_pkg::OUT_W-1:0], sc_q[cis_pkg::OUT_W-1:0]};

	a_shift_range : assert property (@(posedge mclk) disable iff (sys_rst)
		gain_shift_reg <= cis_pkg::SHIFT_MAX)
		else $error("gain shift above limit");
	a_shift_write : assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_wr_en && cfg_addr == cis_pkg::ADDR_SHIFT && cfg_wdata <= cis_pkg::SHIFT_MAX
		|=> gain_shift_reg == $past(cfg_wdata))
		else $error("gain shift write lost");
	a_fifth_write : assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_wr_en && cfg_addr == cis_pkg::ADDR_FIFTH |=> fifth_factor_reg == $past(cfg_wdata))
		else $error("fifth factor write lost");
	a_second_write : assert property (@(posedge mclk) disable iff (sys_rst)
		cfg_wr_en && cfg_addr == cis_pkg::ADDR_SECOND |=> second_factor_reg == $past(cfg_wdata))
		else $error("second factor write lost");
	a_fifth_stuff : assert property (@(posedge mclk) disable iff (sys_rst)
		step5 && ph5_reg != 8'h00 |=> ig5_reg[0][0] == $past(ig5_reg[0][0]))
		else $error("fifth stage fed between samples");
	a_second_stuff : assert property (@(posedge mclk) disable iff (sys_rst)
		adv && ph2_reg != 8'h00 |=> ig2_reg[1][0] == $past(ig2_reg[1][0]))
		else $error("second stage fed between samples");
	a_input_phase : assert property (@(posedge mclk) disable iff (sys_rst)
		hold_full_reg && !need_in |=> hold_full_reg)
		else $error("input consumed off phase");
	a_iq_hold : assert property (@(posedge mclk) disable iff (sys_rst)
		take |=> hold_full_reg && hold_i_reg == $past(in_i) && hold_q_reg == $past(in_q))
		else $error("sample pair not captured together");
	a_scale_exact : assert property (@(posedge mclk) disable iff (sys_rst)
		adv && gain_shift_reg == 8'h00 && !buf_out.valid |=> out_valid &&
		out_q == $past(ig2_reg[1][N2-1][cis_pkg::OUT_W-1:0]))
		else $error("zero shift altered data");
	a_step_rate : assert property (@(posedge mclk) disable iff (sys_rst)
		second_factor_reg == 8'h00 && fifth_factor_reg == 8'h00 && buf_in.ready && hold_full_reg
		|-> step_in)
		else $error("unity factors did not take input");

	c_stall      : cover property (@(posedge mclk) out_valid && !out_ready ##1 out_valid && !out_ready);
	c_take       : cover property (@(posedge mclk) take ##[1:20] step_in);
	c_fifth_wrap : cover property (@(posedge mclk) step5 && ph5_reg != 8'h00 && ph5_reg == fifth_factor_reg);
	c_big_shift  : cover property (@(posedge mclk) adv && gain_shift_reg == cis_pkg::SHIFT_MAX);
endmodule : cis_interpolator
`default_nettype wire

// ### test/cis_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module cis_far_model (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        src_en,
	input  wire logic        stall_en,
	input  wire logic [15:0] dc_i,
	input  wire logic [15:0] dc_q,
	input  wire logic        in_ready,
	output logic      [15:0] in_i,
	output logic      [15:0] in_q,
	output logic             in_valid,
	output logic             out_ready
);
	logic [1:0] tick_reg;
	// sink stalls three cycles in four when asked, to fill the skid buffer
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tick_reg  <= 2'h0;
			out_ready <= 1'b0;
		end
		else
		begin
			tick_reg  <= tick_reg + 2'h1;
			out_ready <= !stall_en || (tick_reg == 2'h0);
		end
	end
	// pair held until taken; released lines show the inverse, never stale data
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			in_valid <= 1'b0;
			in_i     <= 16'h5A5A;
			in_q     <= 16'hA5A5;
		end
		else if (!in_valid || in_ready)
		begin
			in_valid <= src_en;
			in_i     <= src_en ? dc_i : ~in_i;
			in_q     <= src_en ? dc_q : ~in_q;
		end
	end
endmodule : cis_far_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cis_reg_row_type;
	typedef struct {logic [7:0] f5; logic [7:0] f2; logic [7:0] sh; logic [15:0] dc; logic [23:0] ex; logic st;}
		cis_gain_row_type;
	logic        mclk, sys_rst, cfg_wr_en, cfg_rd_en, in_valid, in_ready, out_valid, out_ready;
	logic        src_en, stall_en, hold_reg;
	logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
	logic [15:0] in_i, in_q, dc_i, dc_q;
	logic [23:0] out_i, out_q, hold_i, hold_q;
	int          errors, samples_checked, takes, pops, p0, t0, lf;
	cis_reg_row_type  regs [8] = '{'{8'h06, 8'h03, 8'h03}, '{8'h06, 8'h19, 8'h19}, '{8'h06, 8'h1A, 8'h19},
		'{8'h06, 8'hFF, 8'h19}, '{8'h08, 8'hFF, 8'hFF}, '{8'h09, 8'hA5, 8'hA5}, '{8'h07, 8'h55, 8'h00},
		'{8'h05, 8'h55, 8'h00}};
	// factors kept in the safe range, shift cancels the gain except in rows 1 and 3, which expect dc times the gain, and row 4, which expects a quarter of dc
	cis_gain_row_type gains [6] = '{'{8'h01, 8'h01, 8'h05, 16'h0064, 24'h000064, 1'b0},
		'{8'h00, 8'h02, 8'h00, 16'h0064, 24'h00012C, 1'b0}, '{8'h03, 8'h00, 8'h08, 16'h0100, 24'h000100, 1'b1},
		'{8'h02, 8'h01, 8'h00, 16'h000A, 24'h000654, 1'b0}, '{8'h01, 8'h00, 8'h06, 16'h0040, 24'h000010, 1'b1},
		'{8'h00, 8'h00, 8'h00, 16'h7FFF, 24'h007FFF, 1'b0}};
	cis_interpolator i_dut (.mclk(mclk), .sys_rst(sys_rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_rdata(cfg_rdata), .in_i(in_i), .in_q(in_q),
		.in_valid(in_valid), .in_ready(in_ready), .out_i(out_i), .out_q(out_q), .out_valid(out_valid),
		.out_ready(out_ready));
	cis_far_model i_far (.mclk(mclk), .sys_rst(sys_rst), .src_en(src_en), .stall_en(stall_en), .dc_i(dc_i),
		.dc_q(dc_q), .in_ready(in_ready), .in_i(in_i), .in_q(in_q), .in_valid(in_valid), .out_ready(out_ready));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checked %0d values, %0d mismatches", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// stream monitor: a stalled pair must stand unchanged until popped
	always @(posedge mclk)
	begin
		if (sys_rst)
			hold_reg = 1'b0;
		else
		begin
			if (hold_reg)
				check({out_valid, out_i, out_q}, {1'b1, hold_i, hold_q}, "stalled pair moved");
			takes += int'(in_valid && in_ready);
			pops += int'(out_valid && out_ready);
			hold_reg = out_valid && !out_ready;
			hold_i = out_i;
			hold_q = out_q;
		end
	end
	task automatic do_reset();
		// source stopped too: samples taken before the new factors would leave integrators skewed for good
		{sys_rst, src_en} = 2'b10;
		repeat (8) @(posedge mclk);
		#2;
		check({in_ready, out_valid, cfg_rdata}, 64'h0, "outputs in reset");
		sys_rst = 1'b0;
		@(posedge mclk);
		#2;
		check(in_ready, 1'b1, "ready after reset");
	endtask : do_reset
	task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr_en = 1'b1;
		@(posedge mclk);
		#2;
		cfg_wr_en = 1'b0;
		@(posedge mclk);
		#2;
	endtask : cfg_write
	task automatic cfg_read(input logic [7:0] a, input logic [7:0] e);
		cfg_addr = a;
		cfg_rd_en = 1'b1;
		@(posedge mclk);
		#2;
		cfg_rd_en = 1'b0;
		check(cfg_rdata, e, "register readback");
		@(posedge mclk);
		#2;
	endtask : cfg_read
	task automatic wait_pops(input int n);
		for (int k = 0; k < 12000 && pops < n; k++)
			@(posedge mclk);
		#2;
		if (pops < n)
		begin
			errors++;
			$display("wrong value at %0t ns: output stream stuck", $time);
			end_of_test();
		end
	endtask : wait_pops
	initial
	begin
		{sys_rst, cfg_addr, cfg_wdata, cfg_wr_en, cfg_rd_en, src_en, stall_en} = {1'b1, 21'h0};
		{dc_i, dc_q, errors, samples_checked, takes, pops} = '0;
		do_reset();
		foreach (regs[r])
		begin
			cfg_write(regs[r].a, regs[r].d);
			cfg_read(regs[r].a, regs[r].e);
		end
		$display("register table test done");
		do_reset();
		cfg_read(8'h06, 8'h00);
		cfg_read(8'h08, 8'h00);
		cfg_read(8'h09, 8'h00);
		$display("register reset test done");
		foreach (gains[g])
		begin
			do_reset();
			cfg_write(8'h06, gains[g].sh);
			cfg_write(8'h08, gains[g].f2);
			cfg_write(8'h09, gains[g].f5);
			{dc_i, dc_q, stall_en, src_en} = {gains[g].dc, -gains[g].dc, gains[g].st, 1'b1};
			lf = (int'(gains[g].f5) + 1) * (int'(gains[g].f2) + 1);
			wait_pops(pops + 300);
			{p0, t0} = {pops, takes};
			wait_pops(p0 + 200);
			check(((pops - p0) - (takes - t0) * lf <= 2 * lf + 4) && ((takes - t0) * lf - (pops - p0) <= 2 * lf + 4),
				1'b1, "pairs per output step");
			for (int k = 0; k < 100 && !out_valid; k++)
				@(posedge mclk);
			#2;
			check(out_valid, 1'b1, "output pair present");
			if (!out_valid)
				end_of_test();
			check(out_i, gains[g].ex, "in-phase dc gain");
			check(out_q, 24'(-gains[g].ex), "quadrature dc gain");
			$display("gain row %0d done", g);
		end
		end_of_test();
	end
endmodule : tb
`default_nettype wire
